// ===== rtl/event_counter.sv
// Purpose: one decrementing loop/event counter
// Assumes: load and decrement never both asserted; load wins if they are
// Notes: sign shows the value before any pending decrement
`timescale 1ns/1ns
`default_nettype none
module event_counter #(
  parameter int W = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic load,
  input wire logic dec,
  input wire logic [W-1:0] load_value,
  output logic [W-1:0] count,
  output logic sign
);
  typedef struct packed {
    logic [W-1:0] count;
  } cnt_state_t;

  cnt_state_t cnt_reg;
  cnt_state_t cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next.count = load_value;
    end else if (dec) begin
      cnt_next.count = cnt_reg.count - {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign count = cnt_reg.count;
  assign sign = cnt_reg.count[W-1];
endmodule // event_counter
`default_nettype wire

// ===== rtl/microprogram_sequencer_core.sv
// Purpose: next-address generation core of a 16-bit microprogram sequencer
// Assumes: instruction, data and flag are synchronous to ref_clk; irq lines and trap pin are not
// Notes: latch phases are modelled as edge registers; address leaves one edge after capture
`timescale 1ns/1ns
`default_nettype none
module microprogram_sequencer_core
  import seq_pkg::*;
#(
  parameter logic [15:0] TRAP_ADDR = 16'h0000
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [6:0] microinstruction_bus,
  input wire logic [15:0] bidir_data_port_in,
  input wire logic condition_flag,
  input wire logic [3:0] ext_interrupt_request_lines,
  input wire logic trap_tristate_reset_pin,
  output logic [15:0] microaddress_output_bus,
  output logic microaddress_output_oe_n,
  output logic [15:0] bidir_data_port_out,
  output logic bidir_data_port_oe_n,
  output logic ext_irq_bank_sel
);
  typedef struct packed {
    logic [6:0] instr;
    logic [15:0] data;
    logic [15:0] addr;
    logic [15:0] pc;
    logic [RAM_DEPTH-1:0][15:0] ram;
    logic [NUM_VEC-1:0][15:0] vec;
    logic [NUM_VEC-1:0] pending;
    logic [NUM_VEC-1:0] mask;
    logic ie;
    logic [5:0] subroutine_stack_pointer;
    logic [1:0][5:0] rsp;
    logic rs_sel;
    logic [5:0] limit;
    logic [1:0] width;
    logic [HOLD_W-1:0] hold_cnt;
    logic idle;
    logic sign_status;
    logic [15:0] dout;
    logic drive;
    logic ttr_s1;
    logic ttr_s2;
    logic ttr_prev;
    logic [1:0] ttr_cnt;
    logic trap_pend;
    logic [3:0] ext_s1;
    logic [3:0] ext_s2;
    logic bank;
    logic bank_d1;
    logic bank_d2;
  } core_state_t;

  core_state_t core_reg;
  core_state_t core_next;
  logic [NUM_CNT-1:0] cnt_load;
  logic [NUM_CNT-1:0] cnt_dec;
  logic [NUM_CNT-1:0] cnt_sign;
  logic [NUM_CNT-1:0][15:0] cnt_val;
  logic [15:0] nxt;
  logic [15:0] ext_off;
  logic [15:0] rel_sum;
  logic [15:0] push_val;
  logic [NUM_VEC-1:0] irq_set;
  logic [NUM_VEC-1:0] pend_clr;
  logic [NUM_VEC-1:0] pend_eff;
  logic [3:0] win;
  logic [3:0] vidx;
  logic [1:0] sel_n;
  logic [5:0] ssp_dn;
  logic [5:0] rsp_cur;
  logic [5:0] rs_addr;
  logic [6:0] grp;
  logic any_int;
  logic stack_op;
  logic soft_rst;
  logic trap_req;
  logic take_trap;
  logic take_int;
  logic do_push;
  addr_src_t src;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
      event_counter #(.W(16)) u_cnt (
        .ref_clk(ref_clk),
        .reset(reset),
        .load(cnt_load[gi]),
        .dec(cnt_dec[gi]),
        .load_value(core_reg.data),
        .count(cnt_val[gi]),
        .sign(cnt_sign[gi])
      );
    end
  endgenerate

  always_comb begin
    core_next = core_reg;
    cnt_load = '0;
    cnt_dec = '0;
    irq_set = '0;
    pend_clr = '0;
    win = 4'h0;
    any_int = 1'b0;
    stack_op = 1'b0;
    take_trap = 1'b0;
    take_int = 1'b0;
    do_push = 1'b0;
    src = SRC_PC;
    nxt = core_reg.pc;
    sel_n = core_reg.instr[1:0];
    grp = {core_reg.instr[6:2], 2'b00};
    vidx = 4'(core_reg.instr - OP_WRVEC);
    ssp_dn = core_reg.subroutine_stack_pointer - 6'h01;
    rsp_cur = core_reg.rsp[core_reg.rs_sel];
    rs_addr = rsp_cur + {4'h0, sel_n};
    core_next.idle = 1'b0;
    core_next.drive = 1'b0;
    // two-flop synchronisers for pin inputs
    core_next.ttr_s1 = trap_tristate_reset_pin;
    core_next.ttr_s2 = core_reg.ttr_s1;
    core_next.ttr_prev = core_reg.ttr_s2;
    core_next.ext_s1 = ext_interrupt_request_lines;
    core_next.ext_s2 = core_reg.ext_s1;
    core_next.bank = ~core_reg.bank;
    core_next.bank_d1 = core_reg.bank;
    core_next.bank_d2 = core_reg.bank_d1;
    // trap pin: count consecutive high cycles
    if (core_reg.ttr_s2) begin
      core_next.ttr_cnt = (core_reg.ttr_cnt == TTR_SAT) ? TTR_SAT : core_reg.ttr_cnt + 2'h1;
    end else begin
      core_next.ttr_cnt = 2'h0;
    end
    soft_rst = core_reg.ttr_s2 && (core_reg.ttr_cnt == TTR_RESET_CNT);
    trap_req = core_reg.ttr_prev && !core_reg.ttr_s2 && (core_reg.ttr_cnt != TTR_SAT);
    core_next.trap_pend = core_reg.trap_pend | trap_req;
    // input stage capture, frozen in hold mode
    if (core_reg.hold_cnt != '0) begin
      core_next.hold_cnt = core_reg.hold_cnt - HOLD_W'(1);
    end else begin
      core_next.instr = microinstruction_bus;
      core_next.data = bidir_data_port_in;
    end
    // external requests, bank picked by the external two-to-one mux
    for (int i = 0; i < NUM_EXT; i++) begin
      if (core_reg.ext_s2[i]) begin
        irq_set[IRQ_EXT_BASE + (core_reg.bank_d2 ? NUM_EXT : 0) + i] = 1'b1;
      end
    end
    // offset width control
    case (core_reg.width)
      WIDTH_8: ext_off = {{8{core_reg.data[7]}}, core_reg.data[7:0]};
      WIDTH_12: ext_off = {{4{core_reg.data[11]}}, core_reg.data[11:0]};
      default: ext_off = core_reg.data;
    endcase
    rel_sum = core_reg.pc + ext_off;
    // decode of the latched instruction
    case (core_reg.instr)
      OP_CONT: src = SRC_PC;
      OP_JMP: begin
        src = SRC_ADDER;
        nxt = core_reg.data;
      end
      OP_JREL: begin
        src = SRC_ADDER;
        nxt = rel_sum;
      end
      OP_JIND: begin
        src = SRC_RAM;
        nxt = core_reg.ram[core_reg.data[5:0]];
      end
      OP_CJMP: begin
        if (condition_flag) begin
          src = SRC_ADDER;
          nxt = core_reg.data;
        end
      end
      OP_CJREL: begin
        if (condition_flag) begin
          src = SRC_ADDER;
          nxt = rel_sum;
        end
      end
      OP_CALL: begin
        stack_op = 1'b1;
        core_next.subroutine_stack_pointer = ssp_dn;
        core_next.ram[ssp_dn] = core_reg.pc;
        if (ssp_dn == core_reg.limit) begin
          irq_set[IRQ_STACK] = 1'b1;
        end
        src = SRC_ADDER;
        nxt = core_reg.data;
      end
      OP_RET: begin
        stack_op = 1'b1;
        src = SRC_RAM;
        nxt = core_reg.ram[core_reg.subroutine_stack_pointer];
        core_next.subroutine_stack_pointer = core_reg.subroutine_stack_pointer + 6'h01;
        if (core_reg.subroutine_stack_pointer == SSP_RESET) begin
          irq_set[IRQ_STACK] = 1'b1;
        end
      end
      OP_RS_PUSH: begin
        stack_op = 1'b1;
        core_next.rsp[core_reg.rs_sel] = rsp_cur - 6'h01;
        core_next.ram[rsp_cur - 6'h01] = core_reg.data;
        if ((rsp_cur - 6'h01) == core_reg.subroutine_stack_pointer) begin
          irq_set[IRQ_STACK] = 1'b1;
        end
      end
      OP_RS_POP: begin
        stack_op = 1'b1;
        core_next.dout = core_reg.ram[rsp_cur];
        core_next.drive = 1'b1;
        core_next.rsp[core_reg.rs_sel] = rsp_cur + 6'h01;
      end
      OP_WR_RSP: core_next.rsp[core_reg.rs_sel] = core_reg.data[5:0];
      OP_SEL_RS: core_next.rs_sel = core_reg.data[0];
      OP_WR_MASK: core_next.mask = core_reg.data[NUM_VEC-1:0];
      OP_WR_WIDTH: core_next.width = core_reg.data[1:0];
      OP_WR_LIMIT: core_next.limit = core_reg.data[5:0];
      OP_HOLD: core_next.hold_cnt = core_reg.data[HOLD_W-1:0];
      OP_IDLE: begin
        core_next.idle = 1'b1;
        nxt = core_reg.addr;
      end
      OP_EI: core_next.ie = 1'b1;
      OP_DI: core_next.ie = 1'b0;
      OP_RD_PC: begin
        core_next.dout = core_reg.pc;
        core_next.drive = 1'b1;
      end
      default: begin
        case (grp)
          OP_LDCNT: cnt_load[sel_n] = 1'b1;
          OP_DECCNT: begin
            cnt_dec[sel_n] = 1'b1;
            core_next.sign_status = cnt_sign[sel_n];
          end
          OP_DEC_LOOP: begin
            cnt_dec[sel_n] = 1'b1;
            core_next.sign_status = cnt_sign[sel_n];
            if (!cnt_sign[sel_n]) begin
              src = SRC_ADDER;
              nxt = core_reg.data;
            end
          end
          OP_DEC_INT: begin
            cnt_dec[sel_n] = 1'b1;
            core_next.sign_status = cnt_sign[sel_n];
            if (cnt_sign[sel_n]) begin
              irq_set[IRQ_UNDERFLOW] = 1'b1;
            end
          end
          OP_RDCNT: begin
            core_next.dout = cnt_val[sel_n];
            core_next.drive = 1'b1;
          end
          OP_JRS: begin
            if (condition_flag) begin
              src = SRC_RAM;
              nxt = core_reg.ram[rs_addr];
            end
          end
          OP_WRVEC, OP_WRVEC_B, OP_WRVEC_C: begin
            if (vidx < 4'(NUM_VEC)) begin
              core_next.vec[vidx] = core_reg.data;
            end
          end
          default: src = SRC_PC;
        endcase
      end
    endcase
    // priority decoder: highest index wins
    pend_eff = core_reg.pending & core_reg.mask & {NUM_VEC{core_reg.ie}};
    for (int v = 0; v < NUM_VEC; v++) begin
      if (pend_eff[v]) begin
        win = 4'(v);
        any_int = 1'b1;
      end
    end
    push_val = nxt;
    if (soft_rst) begin
      core_next.subroutine_stack_pointer = SSP_RESET;
      core_next.pending = '0;
      core_next.mask = '0;
      core_next.ie = 1'b0;
      core_next.hold_cnt = '0;
      core_next.idle = 1'b0;
      core_next.trap_pend = 1'b0;
      core_next.drive = 1'b0;
      nxt = ADDR_RESET;
    end else begin
      if (!stack_op && core_reg.trap_pend) begin
        take_trap = 1'b1;
        do_push = 1'b1;
        core_next.trap_pend = trap_req;
        src = SRC_ADDER;
        nxt = TRAP_ADDR;
      end else if (!stack_op && any_int) begin
        take_int = 1'b1;
        do_push = 1'b1;
        pend_clr[win] = 1'b1;
        src = SRC_VEC;
        nxt = core_reg.vec[win];
      end
      if (do_push) begin
        core_next.subroutine_stack_pointer = ssp_dn;
        core_next.ram[ssp_dn] = push_val;
        if (ssp_dn == core_reg.limit) begin
          irq_set[IRQ_STACK] = 1'b1;
        end
      end
      core_next.pending = (core_reg.pending & ~pend_clr) | irq_set;
    end
    core_next.addr = nxt;
    core_next.pc = nxt + 16'h0001;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      core_reg <= '0;
      core_reg.pc <= PC_RESET;
    end else begin
      core_reg <= core_next;
    end
  end

  assign microaddress_output_bus = core_reg.addr;
  assign microaddress_output_oe_n = core_reg.idle | core_reg.ttr_s2;
  assign bidir_data_port_out = core_reg.dout;
  assign bidir_data_port_oe_n = ~core_reg.drive;
  assign ext_irq_bank_sel = core_reg.bank;

  // checking helpers
  logic plain_go;
  logic [15:0] exp_rel8;
  logic [15:0] ind_word;
  assign plain_go = !soft_rst && !take_trap && !take_int;
  assign exp_rel8 = core_reg.pc + {{8{core_reg.data[7]}}, core_reg.data[7:0]};
  assign ind_word = core_reg.ram[core_reg.data[5:0]];

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  chk_pc_follow: assert property (core_reg.pc == core_reg.addr + 16'h0001)
    else $error("program counter is not output address plus one");
  chk_abs_jump: assert property ((core_reg.instr == OP_JMP) && plain_go |=>
    microaddress_output_bus == $past(core_reg.data))
    else $error("absolute jump did not output data port value");
  chk_rel_jump8: assert property ((core_reg.instr == OP_JREL) && (core_reg.width == WIDTH_8) && plain_go |=>
    microaddress_output_bus == $past(exp_rel8))
    else $error("8-bit relative jump target wrong");
  chk_ind_jump: assert property ((core_reg.instr == OP_JIND) && plain_go |=>
    microaddress_output_bus == $past(ind_word))
    else $error("indirect jump did not output RAM word");
  chk_ttr_float: assert property (core_reg.ttr_s2 |-> microaddress_output_oe_n)
    else $error("address drivers on while trap pin high");
  chk_idle_float: assert property ((core_reg.instr == OP_IDLE) && plain_go |=>
    microaddress_output_oe_n && $stable(microaddress_output_bus))
    else $error("idle did not float a steady address");
  chk_ttr_reset: assert property ($rose(core_reg.ttr_s2) ##1 core_reg.ttr_s2 ##1 core_reg.ttr_s2 |=>
    (core_reg.subroutine_stack_pointer == SSP_RESET) && (microaddress_output_bus == ADDR_RESET))
    else $error("three-cycle trap pin did not reset");
  chk_hold_keep: assert property ((core_reg.hold_cnt != '0) |=> $stable(core_reg.instr))
    else $error("held instruction changed");
  chk_int_vector: assert property (take_int |=>
    (microaddress_output_bus == $past(core_reg.vec[win])) && (core_reg.subroutine_stack_pointer == $past(ssp_dn)))
    else $error("interrupt vector not taken");
  chk_cnt_read: assert property ((grp == OP_RDCNT) && (core_reg.instr != OP_RD_PC) && !soft_rst |=>
    !bidir_data_port_oe_n ##1 bidir_data_port_oe_n || $past(grp == OP_RDCNT))
    else $error("counter read not driven for one cycle");
  chk_unused_op: assert property ((grp == 7'h38 || grp == 7'h3C) && plain_go |=>
    microaddress_output_bus == $past(core_reg.pc))
    else $error("unassigned opcode did not advance");
endmodule // microprogram_sequencer_core
`default_nettype wire

// ===== rtl/seq_pkg.sv
// Purpose: constants, opcodes and selector codes of the microprogram sequencer core
// Assumes: single 125 MHz clock, opcode assignment chosen for this core
// Notes: no timescale in packages
`default_nettype none
package seq_pkg;
  localparam int ADDR_W = 16;
  localparam int INSTR_W = 7;
  localparam int RAM_DEPTH = 64;
  localparam int RAM_AW = 6;
  localparam int NUM_VEC = 10;
  localparam int NUM_CNT = 4;
  localparam int NUM_EXT = 4;
  localparam int HOLD_W = 8;
  localparam int IRQ_UNDERFLOW = 0;
  localparam int IRQ_STACK = 9;
  localparam int IRQ_EXT_BASE = 1;
  // single opcodes
  localparam logic [6:0] OP_CONT = 7'h00;
  localparam logic [6:0] OP_JMP = 7'h01;
  localparam logic [6:0] OP_JREL = 7'h02;
  localparam logic [6:0] OP_JIND = 7'h03;
  localparam logic [6:0] OP_CJMP = 7'h04;
  localparam logic [6:0] OP_CJREL = 7'h05;
  localparam logic [6:0] OP_CALL = 7'h06;
  localparam logic [6:0] OP_RET = 7'h07;
  localparam logic [6:0] OP_RS_PUSH = 7'h08;
  localparam logic [6:0] OP_RS_POP = 7'h09;
  localparam logic [6:0] OP_WR_RSP = 7'h0A;
  localparam logic [6:0] OP_SEL_RS = 7'h0B;
  localparam logic [6:0] OP_WR_MASK = 7'h0C;
  localparam logic [6:0] OP_WR_WIDTH = 7'h0D;
  localparam logic [6:0] OP_WR_LIMIT = 7'h0E;
  localparam logic [6:0] OP_HOLD = 7'h0F;
  localparam logic [6:0] OP_IDLE = 7'h10;
  localparam logic [6:0] OP_EI = 7'h11;
  localparam logic [6:0] OP_DI = 7'h12;
  localparam logic [6:0] OP_RD_PC = 7'h13;
  // group opcodes, low two bits pick counter or register
  localparam logic [6:0] OP_LDCNT = 7'h14;
  localparam logic [6:0] OP_DECCNT = 7'h18;
  localparam logic [6:0] OP_RDCNT = 7'h1C;
  localparam logic [6:0] OP_JRS = 7'h20;
  localparam logic [6:0] OP_DEC_INT = 7'h24;
  localparam logic [6:0] OP_WRVEC = 7'h28;
  localparam logic [6:0] OP_WRVEC_B = 7'h2C;
  localparam logic [6:0] OP_WRVEC_C = 7'h30;
  localparam logic [6:0] OP_DEC_LOOP = 7'h34;
  // offset width control
  localparam logic [1:0] WIDTH_FULL = 2'h0;
  localparam logic [1:0] WIDTH_8 = 2'h1;
  localparam logic [1:0] WIDTH_12 = 2'h2;
  // reset values
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [15:0] PC_RESET = 16'h0001;
  localparam logic [5:0] SSP_RESET = 6'h00;
  localparam logic [1:0] TTR_RESET_CNT = 2'h2;
  localparam logic [1:0] TTR_SAT = 2'h3;
  typedef enum logic [1:0] {SRC_PC, SRC_ADDER, SRC_VEC, SRC_RAM} addr_src_t;
endpackage
`default_nettype wire

// ===== test/far_side_model.sv
// Purpose: far side of the sequencer: interrupt bank mux and condition mux
// Assumes: microcode words are presented by the bench itself
// Notes: purely combinational, like the parts it stands for
`timescale 1ns/1ns
`default_nettype none
module far_side_model (
  input wire logic bank_sel,
  input wire logic [3:0] req_lo,
  input wire logic [3:0] req_hi,
  input wire logic [3:0] cond_src,
  input wire logic [1:0] cond_sel,
  output logic [3:0] irq_lines,
  output logic flag
);
  // two-to-one mux doubles the four request lines
  assign irq_lines = bank_sel ? req_hi : req_lo;
  // condition mux picks one test bit
  assign flag = cond_src[cond_sel];
endmodule // far_side_model
`default_nettype wire

// ===== test/tb.sv
// Purpose: self-checking bench for the sequencer core
// Assumes: results appear two edges after the instruction is presented
// Notes: expectations queued by the driver, compared by the monitor
`timescale 1ns/1ns
`default_nettype none
module tb;
  import seq_pkg::*;
  localparam logic [15:0] TRAP_VEC = 16'h0ABC;
  typedef struct {int due; logic [15:0] addr; bit rd; logic [15:0] dv; bit hiz;} note_t;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [6:0] instr = OP_CONT;
  logic [15:0] tb_data = 16'h0000;
  logic [3:0] req_lo = 4'h0;
  logic [3:0] req_hi = 4'h0;
  logic [3:0] cond_src = 4'h0;
  logic [1:0] cond_sel = 2'h0;
  logic trap_pin = 1'b0;
  logic [15:0] addr_out, data_out;
  logic addr_oe_n, data_oe_n, bank_sel, flag;
  logic [3:0] irq_lines;
  wire [15:0] data_bus;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int seed = 91819;
  bit flag_next = 1'b0;
  logic [15:0] exp_addr = 16'h0000;
  note_t notes[$];
  // data port wire: sequencer wins while it drives
  assign data_bus = data_oe_n ? tb_data : data_out;
  far_side_model far (.bank_sel(bank_sel), .req_lo(req_lo), .req_hi(req_hi), .cond_src(cond_src),
    .cond_sel(cond_sel), .irq_lines(irq_lines), .flag(flag));
  microprogram_sequencer_core #(.TRAP_ADDR(TRAP_VEC)) uut (.ref_clk(ref_clk), .reset(reset),
    .microinstruction_bus(instr), .bidir_data_port_in(data_bus), .condition_flag(flag),
    .ext_interrupt_request_lines(irq_lines), .trap_tristate_reset_pin(trap_pin),
    .microaddress_output_bus(addr_out), .microaddress_output_oe_n(addr_oe_n),
    .bidir_data_port_out(data_out), .bidir_data_port_oe_n(data_oe_n), .ext_irq_bank_sel(bank_sel));
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;
  function automatic logic [15:0] rnd16();
    int r;
    r = $random(seed);
    return r[15:0];
  endfunction
  function automatic logic [15:0] nx();
    return exp_addr + 16'h0001;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    samples_checked++;
    if (seen !== want) begin
      err_count++;
      $display("BAD t=%0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask
  task automatic wrap_up();
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic raw(input logic [6:0] op, input logic [15:0] d);
    @(negedge ref_clk);
    instr = op;
    tb_data = d;
  endtask
  // flag is read in the cycle after capture, so it trails by one drive
  task automatic issue(input logic [6:0] op, input logic [15:0] d, input logic [15:0] na,
      input bit f = 1'b0, input bit rd = 1'b0, input logic [15:0] dv = 16'h0000, input bit hiz = 1'b0);
    note_t n;
    logic [15:0] r;
    raw(op, d);
    r = rnd16();
    cond_sel = r[1:0];
    cond_src = r[7:4];
    cond_src[r[1:0]] = flag_next;
    flag_next = f;
    n.due = cyc + 2;
    n.addr = na;
    n.rd = rd;
    n.dv = dv;
    n.hiz = hiz;
    notes.push_back(n);
    exp_addr = na;
  endtask
  task automatic wait_addr(input logic [15:0] want, input bit should);
    bit seen;
    seen = 1'b0;
    for (int i = 0; i < 20 && !seen; i++) begin
      raw(OP_CONT, 16'h0000);
      seen = (addr_out === want);
    end
    check({15'h0000, seen}, {15'h0000, should}, "vector taken");
  endtask
  always @(negedge ref_clk) begin
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      if (notes[0].hiz) begin
        check({15'h0000, addr_oe_n}, 16'h0001, "addr drivers off");
      end else begin
        check({15'h0000, addr_oe_n}, 16'h0000, "addr drivers on");
        check(addr_out, notes[0].addr, "next addr");
      end
      check({15'h0000, data_oe_n}, {15'h0000, ~notes[0].rd}, "data drive");
      if (notes[0].rd) check(data_out, notes[0].dv, "data out");
      void'(notes.pop_front());
    end
  end
  initial begin
    #100000;
    err_count++;
    wrap_up();
  end
  initial begin
    bit seen;
    int bits[3];
    logic [15:0] v, t, ret, vec;
    bits = '{1, 5, 0};
    repeat (20) @(negedge ref_clk);
    check(addr_out, ADDR_RESET, "reset addr");
    check({15'h0000, addr_oe_n}, 16'h0000, "reset addr drive");
    check({15'h0000, data_oe_n}, 16'h0001, "reset data drive");
    check({15'h0000, bank_sel}, 16'h0000, "reset bank");
    reset = 1'b0;
    // the reset-time word and the idle word captured at release each advance once
    exp_addr = PC_RESET + 16'h0001;
    repeat (3) issue(OP_CONT, rnd16(), nx());
    v = rnd16();
    issue(OP_JMP, v, v);
    issue(OP_CONT, 16'h0000, nx());
    v = rnd16();
    issue(OP_JREL, v, nx() + v);
    v = rnd16();
    issue(OP_CJMP, v, nx(), 1'b0);
    issue(OP_CJMP, v, v, 1'b1);
    issue(OP_CJREL, 16'h0040, nx() + 16'h0040, 1'b1);
    ret = nx();
    issue(OP_CALL, 16'h0300, 16'h0300);
    issue(OP_CONT, 16'h0000, nx());
    issue(OP_RET, 16'h0000, ret);
    issue(OP_HOLD, 16'h0002, nx());
    issue(OP_JREL, 16'h0010, nx() + 16'h0010);
    repeat (2) issue(OP_JMP, 16'hFFFF, nx() + 16'h0010);
    issue(OP_CONT, 16'h0000, nx());
    v = rnd16();
    issue(OP_WR_WIDTH, {14'h0000, WIDTH_8}, nx());
    issue(OP_JREL, {v[15:8], 8'h80}, nx() + 16'hFF80);
    issue(OP_WR_WIDTH, {14'h0000, WIDTH_12}, nx());
    issue(OP_JREL, {v[15:12], 12'h801}, nx() + 16'hF801);
    issue(OP_WR_WIDTH, {14'h0000, WIDTH_FULL}, nx());
    v = rnd16();
    t = rnd16();
    issue(OP_WR_RSP, 16'h0020, nx());
    issue(OP_RS_PUSH, v, nx());
    issue(OP_JIND, {t[15:6], 6'h1F}, v);
    issue(OP_JRS, 16'h0000, v, 1'b1);
    issue(OP_RS_POP, 16'h0000, nx(), 1'b0, 1'b1, v);
    issue(OP_RD_PC, 16'h0000, nx(), 1'b0, 1'b1, nx());
    issue(OP_SEL_RS, 16'h0001, nx());
    issue(OP_WR_RSP, 16'h0030, nx());
    issue(OP_RS_PUSH, t, nx());
    issue(OP_JRS, 16'h0000, t, 1'b1);
    issue(OP_SEL_RS, 16'h0000, nx());
    repeat (2) issue(OP_CONT, 16'h0000, nx());
    for (int n = 0; n < NUM_CNT; n++) begin
      v = rnd16();
      issue(OP_LDCNT + 7'(n), v, nx());
      issue(OP_DECCNT + 7'(n), 16'h0000, nx());
      issue(OP_RDCNT + 7'(n), 16'h0000, nx(), 1'b0, 1'b1, v - 16'h0001);
    end
    repeat (2) issue(OP_CONT, 16'h0000, nx());
    t = rnd16();
    issue(OP_LDCNT, 16'h0001, nx());
    repeat (2) issue(OP_DEC_LOOP, t, t);
    issue(OP_DEC_LOOP, t, nx());
    for (logic [7:0] op = 8'h38; op < 8'h80; op++) issue(op[6:0], rnd16(), nx());
    for (int k = 0; k < NUM_VEC; k++) issue(OP_WRVEC + 7'(k), 16'h4000 + 16'(k * 16), nx());
    issue(OP_EI, 16'h0000, nx());
    issue(OP_WR_MASK, 16'h0000, nx());
    foreach (bits[i]) begin
      vec = 16'h4000 + 16'(bits[i] * 16);
      if (bits[i] == 0) begin
        raw(OP_LDCNT, 16'hFFFF);
        raw(OP_DEC_INT, 16'h0000);
      end else if (bits[i] == 1) req_lo[0] = 1'b1;
      else req_hi[0] = 1'b1;
      wait_addr(vec, 1'b0);
      raw(OP_WR_MASK, 16'h0001 << bits[i]);
      wait_addr(vec, 1'b1);
      req_lo = 4'h0;
      req_hi = 4'h0;
      raw(OP_WR_MASK, 16'h0000);
    end
    raw(OP_DI, 16'h0000);
    trap_pin = 1'b1;
    repeat (2) raw(OP_CONT, 16'h0000);
    trap_pin = 1'b0;
    wait_addr(TRAP_VEC, 1'b1);
    issue(OP_IDLE, 16'h0000, nx(), 1'b0, 1'b0, 16'h0000, 1'b1);
    repeat (3) raw(OP_CONT, 16'h0000);
    trap_pin = 1'b1;
    repeat (6) raw(OP_CONT, 16'h0000);
    check({15'h0000, addr_oe_n}, 16'h0001, "drivers off by pin");
    trap_pin = 1'b0;
    seen = 1'b0;
    for (int i = 0; i < 10 && !seen; i++) begin
      raw(OP_CONT, 16'h0000);
      seen = (addr_oe_n === 1'b0);
    end
    check({15'h0000, seen}, 16'h0001, "drivers back after reset");
    wrap_up();
  end
endmodule // tb
`default_nettype wire
